//--- hdl/cfg_serial_pkg.sv
// Purpose: Shared constants for the three-wire configuration link and both of its ends
// Assumes: 50 MHz system clock on both ends
// Notes:   Latch addresses, the test latch included, are fixed here for both ends
package cfg_serial_pkg;

    // Word format
    localparam int          WORD_BITS   = 24;
    localparam int          ADDR_MSB    = 23;
    localparam int          ADDR_LSB    = 21;
    localparam int          BODY_BITS   = 21;
    localparam logic [4:0]  BIT_LAST    = 5'h17;

    // Latch addresses
    localparam logic [2:0]  ADDR_FREQ0  = 3'h0;
    localparam logic [2:0]  ADDR_FREQ1  = 3'h1;
    localparam logic [2:0]  ADDR_GEN    = 3'h2;
    localparam logic [2:0]  ADDR_EN0    = 3'h3;
    localparam logic [2:0]  ADDR_EN1    = 3'h4;
    localparam logic [2:0]  ADDR_TEST   = 3'h7;
    localparam int          LATCH_COUNT = 8;

    // Enable word fields
    localparam int          LNA_LSB     = 0;
    localparam int          MIX_BIT     = 2;
    localparam int          IFA_BIT     = 3;
    localparam int          LIM_BIT     = 4;
    localparam int          SSI_BIT     = 5;
    localparam int          ROUTE_BIT   = 6;
    localparam int          LPF_BIT     = 7;
    localparam int          SLC_BIT     = 8;
    localparam int          PA_LSB      = 9;
    localparam int          OSC_BIT     = 11;
    localparam int          SYN_BIT     = 12;
    localparam int          FREQ_BITS   = 22;

    // Reset values
    localparam logic [20:0] LATCH_RESET = 21'h0;
    localparam logic [23:0] WORD_RESET  = 24'h000000;

    // Host link timing: half a serial clock period
    localparam int          CLK_MHZ     = 50;
    localparam int          HALF_NS     = 80;
    localparam int          HALF_CYC_I  = (HALF_NS * CLK_MHZ) / 1000;
    localparam logic [7:0]  HALF_CYC    = 8'(HALF_CYC_I < 1 ? 1 : HALF_CYC_I);

    // Host register map
    localparam logic [3:0]  REG_WORD    = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h4;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_CNT    = 8;

endpackage : cfg_serial_pkg

//--- hdl/cfg_link_if.sv
// Purpose: Three-wire one-way configuration link between host and device
// Assumes: Host drives every wire; device only listens
// Notes:   No clocking block; the bench joins both ends through this
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
    logic ser_clk;     // Serial clock from host
    logic ser_data;    // Serial data, MSB first
    logic strobe;      // Latch strobe

    modport host (output ser_clk, output ser_data, output strobe);
    modport dev  (input  ser_clk, input  ser_data, input  strobe);
endinterface : cfg_link_if
`default_nettype wire

//--- hdl/cfg_latch_dev.sv
// Purpose: Device end: serial shift register, address decoded latches, enable outputs
// Assumes: Link wires are asynchronous to MCLK and sampled through two flops
//          Host drives clock, data and strobe; the device never answers
// Notes:   RST stands in for power-up; standby does not touch any latch
//          Latch bodies are 21 bits wide; the top frequency bit always reads zero
//
// Contract
// - shift data in on serial clock rise
// - strobe rise loads addressed latch
// - host keeps clock, data low during strobe
// - extra leading bits fall off the top
// - 24-bit words, first bit is MSB
// - port works in active and standby
// - host sends four words, resends changed
// - address 111 writes enter test mode
// - test mode stays until all-clear word
// - host clears test latch after power-up
// - bits 1:0 select amplifier gain mode
// - single-bit block enables, active high
// - bit 6 routes lowpass amp input
// - bits 10:9 power amplifier mode
// - host keeps oscillator enable set
// - bit 12 enables whole synthesizer
// - mode pin picks Mode0 or Mode1 set
// - demodulator auto enabled by three conditions
// - latches retained through standby
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cfg_latch_dev
    import cfg_serial_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    cfg_link_if.dev          link,
    input  wire logic        MODE_SEL,
    input  wire logic        STANDBY,
    output logic [1:0]       LNA_GAIN_SEL,
    output logic             MIXER_EN,
    output logic             IF_AMP_EN,
    output logic             LIMITER_EN,
    output logic             STRENGTH_IND_EN,
    output logic             DEMOD_ROUTE_SEL,
    output logic             LOWPASS_AMP_EN,
    output logic             SLICER_EN,
    output logic [1:0]       TX_AMP_LEVEL,
    output logic             TX_MOD_EN,
    output logic             OSC_EN,
    output logic             SYNTH_EN,
    output logic             DEMOD_EN,
    output logic [21:0]      FREQ_SET,
    output logic [20:0]      GEN_CTRL,
    output logic             TEST_MODE,
    output logic             MODE_ACTIVE,
    output logic             LOAD_DONE
);

    logic [2:0]  clk_sync;
    logic [2:0]  stb_sync;
    logic [1:0]  dat_sync;
    logic [1:0]  mode_sync;
    logic [1:0]  stby_sync;
    logic        clk_rise;
    logic        stb_rise;
    logic [23:0] shift_word;
    logic [20:0] word_latch [LATCH_COUNT];
    logic [2:0]  load_addr;
    logic [20:0] en_word;
    logic [20:0] freq_word;

    // Two-flop synchronisers; a third stage on clock and strobe finds rising edges
    // Data and mode take no edge stage: they are read only as settled levels
    // A glitch shorter than one MCLK period may be missed, never doubled
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            clk_sync  <= 3'h0;
            stb_sync  <= 3'h0;
            dat_sync  <= 2'h0;
            mode_sync <= 2'h0;
            stby_sync <= 2'h0;
        end else begin
            clk_sync  <= {clk_sync[1:0], link.ser_clk};
            stb_sync  <= {stb_sync[1:0], link.strobe};
            dat_sync  <= {dat_sync[0], link.ser_data};
            mode_sync <= {mode_sync[0], MODE_SEL};
            stby_sync <= {stby_sync[0], STANDBY};
        end
    end

    // One pulse per rising edge, read only from settled stages
    assign clk_rise  = clk_sync[1] & ~clk_sync[2];
    assign stb_rise  = stb_sync[1] & ~stb_sync[2];
    assign load_addr = shift_word[ADDR_MSB:ADDR_LSB];

    // Shift register, oldest bit ends at the MSB; surplus leading bits drop out
    // The host keeps the clock low while strobing, so a shift never meets a load
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            shift_word <= WORD_RESET;
        end else if (clk_rise) begin
            shift_word <= {shift_word[WORD_BITS-2:0], dat_sync[1]};
        end
    end

    // Latch array: only the addressed entry loads; standby level is not a term here
    // Each entry loads only on a strobe rise carrying its own address
    // Entries five and six are stored for completeness but drive no output
    genvar gi;
    generate
        for (gi = 0; gi < LATCH_COUNT; gi++) begin : g_latch
            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    word_latch[gi] <= LATCH_RESET;
                end else if (stb_rise && load_addr == 3'(gi)) begin
                    word_latch[gi] <= shift_word[BODY_BITS-1:0];
                end
            end
        end
    endgenerate

    // Test mode: a load of the test latch with a nonzero body sets it, an all-zero body clears it
    // Only a power-on reset or the all-clear word brings the device out again
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TEST_MODE <= 1'b0;
        end else if (stb_rise && load_addr == ADDR_TEST) begin
            TEST_MODE <= |shift_word[BODY_BITS-1:0];
        end
    end

    // Load acknowledge pulse, raised on the same edge that the latch takes the word
    // Outputs show the new word one cycle after this pulse
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            LOAD_DONE <= 1'b0;
        end else begin
            LOAD_DONE <= stb_rise;
        end
    end

    // Active enable word follows the mode pin
    // Whole word sets swap at once, so no reprogramming is needed to switch
    assign en_word = mode_sync[1] ? word_latch[ADDR_EN1] : word_latch[ADDR_EN0];

    // Active frequency word, picked by the same synchronised pin level
    assign freq_word = mode_sync[1] ? word_latch[ADDR_FREQ1] : word_latch[ADDR_FREQ0];

    // Registered decode of the active enable word
    // Amplifier codes 00 and 10 both mean off; the analog side decodes that
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            LNA_GAIN_SEL    <= 2'h0;
            MIXER_EN        <= 1'b0;
            IF_AMP_EN       <= 1'b0;
            LIMITER_EN      <= 1'b0;
            STRENGTH_IND_EN <= 1'b0;
            DEMOD_ROUTE_SEL <= 1'b0;
            LOWPASS_AMP_EN  <= 1'b0;
            SLICER_EN       <= 1'b0;
            TX_AMP_LEVEL    <= 2'h0;
            TX_MOD_EN       <= 1'b0;
            OSC_EN          <= 1'b0;
            SYNTH_EN        <= 1'b0;
            DEMOD_EN        <= 1'b0;
        end else begin
            LNA_GAIN_SEL    <= en_word[LNA_LSB+1:LNA_LSB];
            MIXER_EN        <= en_word[MIX_BIT];
            IF_AMP_EN       <= en_word[IFA_BIT];
            LIMITER_EN      <= en_word[LIM_BIT];
            STRENGTH_IND_EN <= en_word[SSI_BIT];
            DEMOD_ROUTE_SEL <= en_word[ROUTE_BIT];
            LOWPASS_AMP_EN  <= en_word[LPF_BIT];
            SLICER_EN       <= en_word[SLC_BIT];
            TX_AMP_LEVEL    <= en_word[PA_LSB+1:PA_LSB];
            TX_MOD_EN       <= |en_word[PA_LSB+1:PA_LSB];
            OSC_EN          <= en_word[OSC_BIT];
            SYNTH_EN        <= en_word[SYN_BIT];
            DEMOD_EN        <= en_word[LIM_BIT] & en_word[LPF_BIT]
                               & ~en_word[ROUTE_BIT];
        end
    end

    // Frequency and general words, mode indication
    // The body is one bit short of the frequency field, so its top bit is zero
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            FREQ_SET    <= 22'h0;
            GEN_CTRL    <= LATCH_RESET;
            MODE_ACTIVE <= 1'b0;
        end else begin
            FREQ_SET    <= {1'b0, freq_word};
            GEN_CTRL    <= word_latch[ADDR_GEN];
            MODE_ACTIVE <= mode_sync[1];
        end
    end

    // Standby is sampled but deliberately steers nothing: latches keep their content
    // A user may program in standby; nothing gates the shift or the load on it
    logic stby_seen;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            stby_seen <= 1'b0;
        end else begin
            stby_seen <= stby_sync[1];
        end
    end

endmodule : cfg_latch_dev
`default_nettype wire

//--- hdl/cfg_link_host.sv
// Purpose: Host end: Avalon-MM slave that serialises 24-bit words onto the link
// Assumes: Serial clock made here by dividing MCLK
// Notes:   Words written while busy are ignored; poll status before writing
`timescale 1ns/1ps
`default_nettype none
module cfg_link_host
    import cfg_serial_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    cfg_link_if.host         link,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST
);

    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_LOW    = 5'b00010,
        S_HIGH   = 5'b00100,
        S_SETTLE = 5'b01000,
        S_STROBE = 5'b10000
    } host_state_type;

    host_state_type state;
    logic [23:0]    tx_word;
    logic [4:0]     bit_idx;
    logic [7:0]     tick;
    logic [7:0]     sent_cnt;
    logic           take_write;
    logic           tick_end;

    assign take_write = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_WORD
                        && state == S_IDLE;
    assign tick_end   = (tick == HALF_CYC - 8'h01);

    // Wait state: every request gets exactly one wait cycle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        end
    end

    // Read data prepared during the wait cycle; unmapped reads give zero
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= 32'h00000000;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            unique case (AVS_ADDRESS)
                REG_WORD:   AVS_READDATA <= {8'h00, tx_word};
                REG_STATUS: AVS_READDATA <= {16'h0000, sent_cnt, 7'h00, state != S_IDLE};
                default:    AVS_READDATA <= 32'h00000000;
            endcase
        end
    end

    // Half-period timer
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tick <= 8'h00;
        end else if (state == S_IDLE || tick_end) begin
            tick <= 8'h00;
        end else begin
            tick <= tick + 8'h01;
        end
    end

    // Transfer sequencer: 24 clock periods, settle, strobe, then back to idle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state   <= S_IDLE;
            tx_word <= WORD_RESET;
            bit_idx <= 5'h00;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (take_write) begin
                        tx_word <= AVS_WRITEDATA[WORD_BITS-1:0];
                        bit_idx <= 5'h00;
                        state   <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (tick_end) state <= S_HIGH;
                end
                S_HIGH: begin
                    if (tick_end) begin
                        bit_idx <= bit_idx + 5'h01;
                        state   <= (bit_idx == BIT_LAST) ? S_SETTLE : S_LOW;
                    end
                end
                S_SETTLE: begin
                    if (tick_end) state <= S_STROBE;
                end
                S_STROBE: begin
                    if (tick_end) state <= S_IDLE;
                end
            endcase
        end
    end

    // Link wires: data MSB first; clock and data low around and during strobe
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            link.ser_clk  <= 1'b0;
            link.ser_data <= 1'b0;
            link.strobe   <= 1'b0;
        end else begin
            link.ser_clk  <= (state == S_HIGH);
            link.ser_data <= (state == S_LOW || state == S_HIGH)
                             && tx_word[5'(ADDR_MSB) - bit_idx];
            link.strobe   <= (state == S_STROBE);
        end
    end

    // Count of words sent, wraps
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sent_cnt <= 8'h00;
        end else if (state == S_STROBE && tick_end) begin
            sent_cnt <= sent_cnt + 8'h01;
        end
    end

endmodule : cfg_link_host
`default_nettype wire

//--- bench/cfg_link_monitor.sv
// Purpose: Concurrent checks on the link wires and device outputs
// Assumes: Both ends run on MCLK
// Notes:   Instantiated once beside the link
`timescale 1ns/1ps
`default_nettype none
module cfg_link_monitor (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       ser_clk,
    input wire logic       ser_data,
    input wire logic       strobe,
    input wire logic       LOAD_DONE,
    input wire logic       TEST_MODE,
    input wire logic       DEMOD_EN,
    input wire logic       LIMITER_EN,
    input wire logic       LOWPASS_AMP_EN,
    input wire logic       DEMOD_ROUTE_SEL,
    input wire logic       TX_MOD_EN,
    input wire logic [1:0] TX_AMP_LEVEL
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Host wire discipline
    chk_strobe_quiet: assert property (strobe |-> !ser_clk && !ser_data)
        else $error("clock or data high during strobe");
    chk_clk_high: assert property ($rose(ser_clk) |-> ser_clk[*4] ##1 !ser_clk)
        else $error("serial clock high phase wrong");
    chk_data_hold: assert property (ser_clk |-> $stable(ser_data))
        else $error("data moved while clock high");
    chk_strobe_len: assert property ($rose(strobe) |-> strobe[*4] ##1 !strobe)
        else $error("strobe length wrong");
    // Device load timing and derived enables
    chk_load_time: assert property ($rose(strobe) |-> ##[2:5] LOAD_DONE)
        else $error("no load after strobe");
    chk_load_once: assert property (LOAD_DONE |=> !LOAD_DONE)
        else $error("load acted twice");
    chk_test_cause: assert property ($changed(TEST_MODE) |-> LOAD_DONE)
        else $error("test mode moved without load");
    chk_demod_auto: assert property (DEMOD_EN == (LIMITER_EN && LOWPASS_AMP_EN && !DEMOD_ROUTE_SEL))
        else $error("demodulator enable wrong");
    chk_tx_mod: assert property (TX_MOD_EN == (|TX_AMP_LEVEL))
        else $error("modulation enable wrong");
endmodule : cfg_link_monitor
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: Drives host registers and judges device latches
// Assumes: Host and device joined by one link
// Notes:   Words go out only when host is idle
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cfg_serial_pkg::*;
;
    logic        mclk, rst, mode_sel, stby, rd, wr, wreq;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat;
    logic [1:0]  lna, txl;
    logic        mix, ifa, lim, ssi, route, lpf, slc, txm, osc, syn, dem, tst, mact, ld;
    logic [21:0] freq;
    logic [20:0] gen;
    logic [12:0] en;
    logic [7:0]  sent;
    int          num_errors, num_checks;
    // Enable word as seen at the outputs
    assign en = {syn, osc, txl, slc, lpf, route, ssi, lim, ifa, mix, lna};
    cfg_link_if link ();
    cfg_link_host u_cfg_link_host (.MCLK(mclk), .RST(rst), .link(link.host), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq));
    cfg_latch_dev u_cfg_latch_dev (.MCLK(mclk), .RST(rst), .link(link.dev), .MODE_SEL(mode_sel),
        .STANDBY(stby), .LNA_GAIN_SEL(lna), .MIXER_EN(mix), .IF_AMP_EN(ifa), .LIMITER_EN(lim),
        .STRENGTH_IND_EN(ssi), .DEMOD_ROUTE_SEL(route), .LOWPASS_AMP_EN(lpf), .SLICER_EN(slc),
        .TX_AMP_LEVEL(txl), .TX_MOD_EN(txm), .OSC_EN(osc), .SYNTH_EN(syn), .DEMOD_EN(dem),
        .FREQ_SET(freq), .GEN_CTRL(gen), .TEST_MODE(tst), .MODE_ACTIVE(mact), .LOAD_DONE(ld));
    cfg_link_monitor u_cfg_link_monitor (.MCLK(mclk), .RST(rst), .ser_clk(link.ser_clk),
        .ser_data(link.ser_data), .strobe(link.strobe), .LOAD_DONE(ld), .TEST_MODE(tst),
        .DEMOD_EN(dem), .LIMITER_EN(lim), .LOWPASS_AMP_EN(lpf), .DEMOD_ROUTE_SEL(route),
        .TX_MOD_EN(txm), .TX_AMP_LEVEL(txl));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic timed_out;
        num_errors++;
        $display("[ERR] %0t wait timed out", $time);
        complete_run();
    endtask : timed_out
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 100) timed_out();
        @(posedge mclk);
    endtask : bus
    // Send one word once idle, then wait for the device load
    task automatic send(input logic [23:0] w);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0, s);
            n++;
        end while (s[STAT_BUSY] !== 1'b0 && n < 400);
        if (s[STAT_BUSY] !== 1'b0) timed_out();
        bus(1'b1, REG_WORD, {8'ha5, w}, s);
        sent++;
        for (n = 0; n < 400 && ld !== 1'b1; n++) @(posedge mclk);
        if (n >= 400) timed_out();
        repeat (2) @(posedge mclk);
    endtask : send
    task automatic t_reset;
        logic [31:0] s;
        check(32'(en), 32'h0);
        check(32'({dem, txm, tst}), 32'h0);
        check(32'(syn), 32'h0);
        check(32'(freq), 32'h0);
        check(32'(gen), 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, s);
        check(s, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_test;
        send(24'he00000);
        check(32'(tst), 32'h0);
        send(24'he00001);
        check(32'(tst), 32'h1);
        send(24'h600000);
        check(32'(tst), 32'h1);
        send(24'he00000);
        check(32'(tst), 32'h0);
        $display("test test_latch done");
    endtask : t_test
    task automatic t_enables;
        logic [12:0] tbl [4] = '{13'h0000, 13'h1fff, 13'h0402, 13'h12b5};
        for (int i = 0; i < 4; i++) begin
            stby <= i[0];
            send({11'h300, tbl[i]});
            check(32'(en), 32'(tbl[i]));
            check(32'(dem), 32'(tbl[i][4] & tbl[i][7] & ~tbl[i][6]));
            check(32'(txm), 32'(|tbl[i][10:9]));
            check(32'(osc), 32'(tbl[i][OSC_BIT]));
        end
        stby <= 1'b0;
        repeat (3) @(posedge mclk);
        check(32'(en), 32'h12b5);
        $display("test enables done");
    endtask : t_enables
    task automatic t_modes;
        int n;
        send(24'h0abcde);
        send(24'h212345);
        send(24'h800a5a);
        send(24'h455555);
        check(32'(freq), 32'h0abcde);
        check(32'(en), 32'h12b5);
        check(32'(gen), 32'h055555);
        mode_sel <= 1'b1;
        for (n = 0; n < 20 && mact !== 1'b1; n++) @(posedge mclk);
        if (mact !== 1'b1) timed_out();
        @(posedge mclk);
        check(32'(mact), 32'h1);
        check(32'(freq), 32'h012345);
        check(32'(en), 32'h0a5a);
        mode_sel <= 1'b0;
        for (n = 0; n < 20 && mact !== 1'b0; n++) @(posedge mclk);
        if (mact !== 1'b0) timed_out();
        @(posedge mclk);
        check(32'(mact), 32'h0);
        check(32'(freq), 32'h0abcde);
        check(32'(en), 32'h12b5);
        $display("test modes done");
    endtask : t_modes
    task automatic t_host;
        logic [31:0] s;
        bus(1'b0, REG_WORD, 32'h0, s);
        check(32'(s[23:0]), 32'h455555);
        bus(1'b1, REG_WORD, 32'h00455555, s);
        sent++;
        bus(1'b1, REG_WORD, 32'h00e00001, s);
        bus(1'b0, REG_WORD, 32'h0, s);
        check(32'(s[23:0]), 32'h455555);
        bus(1'b0, REG_STATUS, 32'h0, s);
        check(32'(s[STAT_BUSY]), 32'h1);
        send(24'h455555);
        check(32'(tst), 32'h0);
        bus(1'b1, 4'hc, 32'h00e00001, s);
        bus(1'b0, 4'h8, 32'h0, s);
        check(s, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0, s);
        check(32'(s[15:0]), {16'h0, sent, 8'h00});
        $display("test host done");
    endtask : t_host
    // Main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        sent = 8'h00;
        rst = 1'b1;
        mode_sel = 1'b0;
        stby = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_test();
        t_enables();
        t_modes();
        t_host();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
